/* File: rtl/quad_adc_defines.vh */
// Notes on behaviour
// - Frame-sync output is used only in external clock mode.
// - External read start gives one sync pulse, one serial clock wide.
// - Clock pin drives out in internal mode, is an input in external.
// - Internal mode: each conversion start gives 16 serial clock periods.
// - Internal mode: data bit stable across both edges of its clock.
// - Result kept in on-chip shift register, sent MSB first.
// - External mode: read old result in conversion or new one after.
// - Chip select fall with read/convert low starts a conversion.
// - External mode: chip select fall with read/convert high starts serial output.
// - Busy low from conversion start until result is in shift register.
// - Both address write strobes are ORed into the latch enable.
// - Address latch is transparent while both write strobes are low.
// - Channel address inputs are captured by the strobed latch.
// - Latched address 00..11 selects channel 1..4, upper bit first.
// - Chip select low: read/convert fall converts, rise starts a read in external mode.
// - Power-down inhibits conversions and keeps the stored result.
// - Internal frame after a start carries the preceding result.
`ifndef QUAD_ADC_DEFINES_VH
`define QUAD_ADC_DEFINES_VH

`define QADC_WIDTH        16
`define QADC_MSB_IDX      4'hf
`define QADC_CONV_CYCLES  400
`define QADC_PHASE_CYCLES 4'h2
`define QADC_ADDR_RST     2'h0
`define QADC_RESULT_RST   16'h0000
`define QADC_BUF_AW       1

`endif

/* File: rtl/quad_adc_serial_readout.v */
`timescale 1ns/1ps
`include "quad_adc_defines.vh"

module quad_adc_serial_readout #(
  parameter CONV_CYCLES = `QADC_CONV_CYCLES,
  parameter BUF_AW      = `QADC_BUF_AW
) (
  input  wire                   i_clk,
  input  wire                   i_rst,
  input  wire                   i_cs_n,
  input  wire                   i_read_convert,
  input  wire                   i_clock_source_select,
  input  wire                   i_addr_write_strobe_a,
  input  wire                   i_addr_write_strobe_b,
  input  wire                   i_chan_addr_hi,
  input  wire                   i_chan_addr_lo,
  input  wire                   i_power_down_in,
  input  wire                   i_serial_clock_pin,
  input  wire [`QADC_WIDTH-1:0] i_conv_data,
  output reg                    o_serial_clock_pin,
  output reg                    o_serial_clock_oe_n,
  output reg                    o_serial_data,
  output reg                    o_sync,
  output reg                    o_busy_n,
  output reg                    o_sample_hold,
  output reg  [1:0]             o_analog_channel
);

  // Conversion and serial sides run as two separate state machines
  localparam C_IDLE = 3'b001;
  localparam C_CONV = 3'b010;
  localparam C_WAIT = 3'b100;
  localparam S_IDLE = 4'b0001;
  localparam S_INT  = 4'b0010;
  localparam S_ARM  = 4'b0100;
  localparam S_EXT  = 4'b1000;
  localparam DEPTH  = 1 << BUF_AW;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  reg  [8:0] pin_s1_reg;
  reg  [8:0] pin_s2_reg;
  reg  [8:0] pin_prev_reg;
  wire [8:0] pins;

  assign pins = {i_serial_clock_pin, i_power_down_in, i_chan_addr_lo,
                 i_chan_addr_hi, i_addr_write_strobe_b,
                 i_addr_write_strobe_a, i_clock_source_select,
                 i_read_convert, i_cs_n};

  // Reset leaves chip select and read/convert high, so release is no edge
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1_reg   <= 9'h003;
      pin_s2_reg   <= 9'h003;
      pin_prev_reg <= 9'h003;
    end
    else
    begin
      pin_s1_reg   <= pins;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  wire cs_n     = pin_s2_reg[0];
  wire rc       = pin_s2_reg[1];
  wire ext_sel  = pin_s2_reg[2];
  wire wr_a     = pin_s2_reg[3];
  wire wr_b     = pin_s2_reg[4];
  wire pd       = pin_s2_reg[7];
  wire addr_hi  = pin_s2_reg[5];
  wire addr_lo  = pin_s2_reg[6];
  wire cs_fall  = pin_prev_reg[0] & ~cs_n;
  wire rc_fall  = pin_prev_reg[1] & ~rc;
  wire rc_rise  = ~pin_prev_reg[1] & rc;
  wire sck_fall = pin_prev_reg[8] & ~pin_s2_reg[8];

  // Either control pin may go low last; the later edge fires the start
  wire conv_req = (cs_fall & ~rc) | (rc_fall & ~cs_n);
  wire read_req = (cs_fall & rc) | (rc_rise & ~cs_n);

  ////////////////////////////////////////////////////////////////////////////
  // Channel address latch

  // Strobes and address bits share one sync depth, so a strobe that rises
  // with an address change still closes the latch on the old address
  wire latch_en = wr_a | wr_b;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_analog_channel <= `QADC_ADDR_RST;
    else if (!latch_en)
      o_analog_channel <= {addr_hi, addr_lo};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing

  reg  [2:0]  cstate_reg;
  reg  [15:0] ccnt_reg;
  reg  [3:0]  sstate_reg;
  wire        conv_start;
  wire        push_valid;
  wire        push_ready;
  wire        pop_valid;
  wire        pop_ready;
  wire [`QADC_WIDTH-1:0] pop_data;

  // Starts that arrive while busy or powered down are dropped, not queued
  assign conv_start = conv_req & ~pd & cstate_reg[0];
  assign push_valid = cstate_reg[1] &
                      (ccnt_reg == CONV_CYCLES[15:0] - 16'h0001);
  // Only reload while nothing is being sent, so a read never tears
  assign pop_ready  = sstate_reg[0] & ~conv_start & ~read_req;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cstate_reg    <= C_IDLE;
      ccnt_reg      <= 16'h0000;
      o_busy_n      <= 1'b1;
      o_sample_hold <= 1'b0;
    end
    else
    begin
      o_sample_hold <= conv_start;
      case (cstate_reg)
        C_IDLE:
          if (conv_start)
          begin
            cstate_reg <= C_CONV;
            ccnt_reg   <= 16'h0000;
            o_busy_n   <= 1'b0;
          end
        C_CONV:
          if (push_valid)
          begin
            if (push_ready)
              cstate_reg <= C_WAIT;
          end
          else
            ccnt_reg <= ccnt_reg + 16'h0001;
        C_WAIT:
          if (pop_valid & pop_ready)
          begin
            cstate_reg <= C_IDLE;
            o_busy_n   <= 1'b1;
          end
        default:
          cstate_reg <= C_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer
  // Holding a finished word here keeps busy low until no frame is sending,
  // so the shift register never changes under a running read

  reg  [`QADC_WIDTH-1:0] buf_mem [0:DEPTH-1];
  reg  [BUF_AW-1:0]      wptr_reg;
  reg  [BUF_AW-1:0]      rptr_reg;
  reg  [BUF_AW:0]        fill_reg;
  wire                   do_push = push_valid & push_ready;
  wire                   do_pop  = pop_valid & pop_ready;

  assign push_ready = (fill_reg != DEPTH[BUF_AW:0]);
  assign pop_valid  = (fill_reg != {(BUF_AW+1){1'b0}});
  assign pop_data   = buf_mem[rptr_reg];

  // Storage has no reset; only entries counted as full are ever read
  always @(posedge i_clk)
  begin
    if (do_push)
      buf_mem[wptr_reg] <= i_conv_data;
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wptr_reg <= {BUF_AW{1'b0}};
      rptr_reg <= {BUF_AW{1'b0}};
      fill_reg <= {(BUF_AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wptr_reg <= wptr_reg + {{(BUF_AW-1){1'b0}}, 1'b1};
      if (do_pop)
        rptr_reg <= rptr_reg + {{(BUF_AW-1){1'b0}}, 1'b1};
      if (do_push & ~do_pop)
        fill_reg <= fill_reg + {{BUF_AW{1'b0}}, 1'b1};
      else if (do_pop & ~do_push)
        fill_reg <= fill_reg - {{BUF_AW{1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  reg [`QADC_WIDTH-1:0] shift_reg;
  reg [3:0]             idx_reg;
  reg [3:0]             tick_reg;
  reg [1:0]             ph_reg;
  wire                  tick_end = (tick_reg == `QADC_PHASE_CYCLES - 4'h1);

  // Bits are picked by index so the result survives repeated reads
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sstate_reg          <= S_IDLE;
      shift_reg           <= `QADC_RESULT_RST;
      idx_reg             <= `QADC_MSB_IDX;
      tick_reg            <= 4'h0;
      ph_reg              <= 2'h0;
      o_serial_clock_pin  <= 1'b0;
      o_serial_clock_oe_n <= 1'b0;
      o_serial_data       <= 1'b0;
      o_sync              <= 1'b0;
    end
    else
    begin
      o_serial_clock_oe_n <= ext_sel;
      if (do_pop)
        shift_reg <= pop_data;
      case (sstate_reg)
        S_IDLE:
        begin
          o_sync <= 1'b0;
          if (conv_start & ~ext_sel)
          begin
            sstate_reg    <= S_INT;
            idx_reg       <= `QADC_MSB_IDX;
            tick_reg      <= 4'h0;
            ph_reg        <= 2'h0;
            o_serial_data <= shift_reg[`QADC_MSB_IDX];
          end
          else if (read_req & ext_sel)
            sstate_reg <= S_ARM;
        end
        S_INT:
        begin
          // Data moves only in phase 0, clock rises in 1 and falls in 2
          tick_reg <= tick_end ? 4'h0 : tick_reg + 4'h1;
          if (tick_end)
          begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0)
              o_serial_clock_pin <= 1'b1;
            else if (ph_reg == 2'h1)
              o_serial_clock_pin <= 1'b0;
            else if (ph_reg == 2'h3)
            begin
              if (idx_reg == 4'h0)
                sstate_reg <= S_IDLE;
              else
              begin
                idx_reg       <= idx_reg - 4'h1;
                o_serial_data <= shift_reg[idx_reg - 4'h1];
              end
            end
          end
        end
        // Host falls arrive about three cycles late through the synchroniser
        S_ARM:
          if (~ext_sel)
            sstate_reg <= S_IDLE;
          else if (sck_fall)
          begin
            sstate_reg    <= S_EXT;
            o_sync        <= 1'b1;
            idx_reg       <= `QADC_MSB_IDX;
            o_serial_data <= shift_reg[`QADC_MSB_IDX];
          end
        S_EXT:
          if (~ext_sel)
            sstate_reg <= S_IDLE;
          else if (sck_fall)
          begin
            o_sync <= 1'b0;
            if (idx_reg == 4'h0)
              sstate_reg <= S_IDLE;
            else
            begin
              idx_reg       <= idx_reg - 4'h1;
              o_serial_data <= shift_reg[idx_reg - 4'h1];
            end
          end
        default:
          sstate_reg <= S_IDLE;
      endcase
    end
  end

endmodule // quad_adc_serial_readout

/* File: tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire i_pin,
  input  wire i_data,
  input  wire i_sync,
  output reg  o_sclk
);
  reg [15:0] word;
  reg [16:0] sync_hist;
  int        nbits;
  initial o_sclk = 1'b0;
  initial nbits = 0;
  always @(posedge i_pin)
  begin
    word      = {word[14:0], i_data};
    sync_hist = {sync_hist[15:0], i_sync};
    nbits     = nbits + 1;
  end
  // Clock stands low between frames; the first fall launches the MSB,
  // so 17 pulses are needed to capture 16 bits on rising edges
  task ext_read;
  begin
    #3;
    repeat (17)
    begin
      #40 o_sclk = 1'b1;
      #40 o_sclk = 1'b0;
    end
  end
  endtask
endmodule // host_model

/* File: tb/quad_adc_serial_readout_chk.sv */
`timescale 1ns/1ps
module quad_adc_serial_readout_chk #(
  parameter CONV_CYCLES = 400
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_clock_source_select,
  input wire i_power_down_in,
  input wire o_serial_clock_pin,
  input wire o_serial_clock_oe_n,
  input wire o_serial_data,
  input wire o_sync,
  input wire o_busy_n,
  input wire o_sample_hold
);
  reg [15:0] low_cnt_reg;
  reg [4:0]  rise_cnt_reg;
  reg        clk_d_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      low_cnt_reg  <= 16'h0000;
      rise_cnt_reg <= 5'h00;
      clk_d_reg    <= 1'b0;
    end
    else
    begin
      low_cnt_reg  <= o_busy_n ? 16'h0000 : low_cnt_reg + 16'h0001;
      clk_d_reg    <= o_serial_clock_pin;
      if (o_sample_hold)
        rise_cnt_reg <= 5'h00;
      else if (o_serial_clock_pin && !clk_d_reg)
        rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
  end
  ext_oe_off_a: assert property (i_clock_source_select [*5] |=>
    o_serial_clock_oe_n) else $error("clock pin driven in ext mode");
  int_oe_on_a: assert property (!i_clock_source_select [*5] |=>
    !o_serial_clock_oe_n) else $error("clock pin released in int mode");
  sync_ext_only_a: assert property (o_sync |->
    o_serial_clock_oe_n) else $error("sync outside ext mode");
  sync_width_a: assert property ($rose(o_sync) |->
    o_sync [*6] ##[1:4] !o_sync) else $error("sync width wrong");
  start_busy_a: assert property ($fell(o_busy_n) |->
    o_sample_hold) else $error("busy fell without start");
  busy_len_a: assert property ($rose(o_busy_n) |->
    low_cnt_reg >= CONV_CYCLES + 1) else $error("busy low too short");
  pd_inhibit_a: assert property (i_power_down_in [*4] |=>
    !o_sample_hold) else $error("start under power down");
  frame_count_a: assert property (
    o_sample_hold && !o_serial_clock_oe_n |->
    rise_cnt_reg == 5'h10 || rise_cnt_reg == 5'h00)
    else $error("bad pulse count");
  data_steady_a: assert property ((o_serial_clock_pin ||
    $fell(o_serial_clock_pin)) && !o_serial_clock_oe_n |->
    $stable(o_serial_data)) else $error("data moved inside clock period");
endmodule // quad_adc_serial_readout_chk
bind quad_adc_serial_readout quad_adc_serial_readout_chk #(
  .CONV_CYCLES(CONV_CYCLES)) quad_adc_serial_readout_chk_inst (.i_clk,
  .i_rst, .i_clock_source_select, .i_power_down_in, .o_serial_clock_pin,
  .o_serial_clock_oe_n, .o_serial_data, .o_sync, .o_busy_n, .o_sample_hold);

/* File: tb/tb_quad_adc_serial_readout.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_quad_adc_serial_readout;
  reg        i_clk = 1'b0, i_rst = 1'b1, cs_n = 1'b1, rc = 1'b1;
  reg        sel = 1'b0, wa = 1'b0, wb = 1'b0, hi = 1'b0, lo = 1'b0;
  reg        pd = 1'b0, started;
  reg [15:0] din = 16'h0000, prev = 16'h0000, lfsr = 16'h0062, d;
  wire       sclk_o, oe_n, sdat, sync, busy_n, sh, hclk;
  wire [1:0] ch;
  wire       pin = oe_n ? hclk : sclk_o;
  int        n_errors = 0, checks = 0, i, k, nb0;
  always #5 i_clk = ~i_clk;
  quad_adc_serial_readout #(.CONV_CYCLES(40)) quad_adc_serial_readout_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_read_convert(rc),
    .i_clock_source_select(sel), .i_addr_write_strobe_a(wa),
    .i_addr_write_strobe_b(wb), .i_chan_addr_hi(hi), .i_chan_addr_lo(lo),
    .i_power_down_in(pd), .i_serial_clock_pin(pin), .i_conv_data(din),
    .o_serial_clock_pin(sclk_o), .o_serial_clock_oe_n(oe_n),
    .o_serial_data(sdat), .o_sync(sync), .o_busy_n(busy_n),
    .o_sample_hold(sh), .o_analog_channel(ch));
  host_model host_model_inst (.i_pin(pin), .i_data(sdat), .i_sync(sync),
    .o_sclk(hclk));
  function [15:0] nxt(input [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task summarize;
  begin
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task conv(input [15:0] v, input exp);
  begin
    nb0 = host_model_inst.nbits;
    din <= v;
    rc  <= 1'b0;
    for (i = 0; i < 8 && busy_n === 1'b1; i++) @(posedge i_clk);
    started = (busy_n === 1'b0);
    `CHK(started, exp)
    rc <= 1'b1;
    for (i = 0; i < 400 && busy_n !== 1'b1; i++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  end
  endtask
  task ext_chk(input [15:0] v);
  begin
    host_model_inst.ext_read;
    @(posedge i_clk);
    `CHK(host_model_inst.word, v)
    `CHK(host_model_inst.sync_hist, 17'h08000)
  end
  endtask
  initial
  begin
    #200000;
    n_errors++;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    cs_n  <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      {hi, lo} <= k[1:0];
      d = (k == 0) ? 16'h8001 : lfsr;
      lfsr = nxt(lfsr);
      conv(d, 1'b1);
      `CHK(host_model_inst.word, prev)
      `CHK(host_model_inst.nbits - nb0, 16)
      `CHK(ch, k[1:0])
      prev = d;
    end
    $display("internal readout done");
    pd <= 1'b1;
    repeat (4) @(posedge i_clk);
    conv(lfsr, 1'b0);
    `CHK(host_model_inst.nbits - nb0, 0)
    pd <= 1'b0;
    repeat (4) @(posedge i_clk);
    d = nxt(lfsr);
    lfsr = nxt(d);
    conv(d, 1'b1);
    `CHK(host_model_inst.word, prev)
    prev = d;
    $display("power down done");
    for (k = 0; k < 2; k++)
    begin
      {wa, wb} <= k ? 2'b01 : 2'b10;
      repeat (4) @(posedge i_clk);
      {hi, lo} <= {2{k[0]}};
      repeat (6) @(posedge i_clk);
      `CHK(ch, ~{2{k[0]}})
      {wa, wb} <= 2'b00;
      repeat (6) @(posedge i_clk);
      `CHK(ch, {2{k[0]}})
    end
    $display("address latch done");
    sel  <= 1'b1;
    cs_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    `CHK(oe_n, 1'b1)
    cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    ext_chk(prev);
    din <= lfsr;
    rc  <= 1'b0;
    repeat (6) @(posedge i_clk);
    rc  <= 1'b1;
    repeat (6) @(posedge i_clk);
    ext_chk(prev);
    cs_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    ext_chk(lfsr);
    $display("external readout done");
    summarize;
  end
endmodule // tb_quad_adc_serial_readout
